// ===== hw/cache_diag_consts.svh
// Purpose: Address, field and offset constants of the cache diagnostic block
// Assumes: Included by its bare name from design and bench files
// Notes:   Definitions only
`ifndef CACHE_DIAG_CONSTS_SVH
`define CACHE_DIAG_CONSTS_SVH

`define CD_ASI_ITAG      8'h0c
`define CD_ASI_IDATA     8'h0d
`define CD_ASI_DTAG      8'h0e
`define CD_ASI_DDATA     8'h0f

`define CD_BANK_BIT      31
`define CD_INV_OFS_16K   31'h0000_8000
`define CD_INV_OFS_OTHER 31'h0000_1000
`define CD_LIM_16K       31'h0000_2000
`define CD_LIM_8K        31'h0000_1000
`define CD_LIM_4K        31'h0000_0800
`define CD_LIM_SMALL     31'h0000_0400

`define CD_LINE32_HI     12
`define CD_LINE32_LO     5
`define CD_LINE16_HI     9
`define CD_LINE16_LO     4
`define CD_WORD_HI       12
`define CD_WORD_LO       2

`define CD_TAG_HI        31
`define CD_TAG_LO        10
`define CD_B12           12
`define CD_B11           11
`define CD_B10           10
`define CD_SBV_HI        9
`define CD_SBV_LO        6
`define CD_PRIV          5
`define CD_SBV2_HI       4
`define CD_SBV2_LO       2
`define CD_LRU           1
`define CD_LOCK          0
`define CD_INV_LRU_LOCK  1
`define CD_INV_VALID     0

`endif

// ===== hw/cache_diag_pkg.sv
// Purpose: Types shared by the cache diagnostic block
// Assumes: Nothing beyond SystemVerilog
// Notes:   Capacity codes follow a Gray walk from largest to smallest
`default_nettype none
package cache_diag_pkg;
  typedef enum logic [2:0] {
    CAP_16K = 3'h0,
    CAP_8K  = 3'h1,
    CAP_4K  = 3'h3,
    CAP_2K  = 3'h2,
    CAP_1K  = 3'h6
  } cap_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  asi;
    logic [31:0] addr;
    logic [31:0] wdata;
  } asi_req_t;

  typedef struct packed {
    logic        ack;
    logic        unmapped;
    logic [31:0] rdata;
  } asi_rsp_t;
endpackage
`default_nettype wire

// ===== hw/cache_diagnostic_access.sv
// Purpose: Alternate-space diagnostic access to tags, data RAM and bulk invalidate
// Assumes: One request per cycle at most; capacity stable while accessing
// Notes:   Answers one cycle after the request; unmapped reads return zero
`default_nettype none
`include "cache_diag_consts.svh"

// Contract
// - Instruction tags at space 0x0c, bit 31 picks bank two, 32/16-byte line steps.
// - Data tags at space 0x0e, same banks, ranges and steps.
// - Instruction data RAM at space 0x0d, 32-bit words, 4-byte steps, no reset.
// - Data-cache data RAM at space 0x0f, bit 31 picks bank two, sized by capacity.
// - Tag bits 31..13 hold tag; bit 12 reserved at 16KB, bit 11 at 16/8KB.
// - Bit 10 is sub-block valid at 16/8/4KB, address tag at 2/1KB.
// - Bits 9..6 valid, reset clear; bits 4..2 valid at 4KB up, else reserved.
// - Instruction tag bit 5 is privilege: zero user, one supervisor.
// - Data tag bit 5 is privilege: one user, zero supervisor.
// - Bit 0 is the entry lock flag, one locked, reset clear.
// - Invalidate register at bank offset 0x8000 for 16KB, 0x1000 otherwise.
// - Invalidate bit 1 set clears LRU and lock bits of addressed bank.
// - Invalidate bit 0 set clears valid bits of addressed bank.
// - At 1KB only bank two decodes, up to offset 0x3f0 at 16-byte steps.
module cache_diagnostic_access #(
  parameter int LINES = 256,   // Tag entries per bank at the largest capacity
  parameter int WORDS = 2048   // Data words per bank at the largest capacity
) (
  input  wire logic                    clk_sys,  // Core clock
  input  wire logic                    rst_n,    // Async reset, active low
  input  wire cache_diag_pkg::cap_t    cap_sel,  // Configured cache capacity
  input  wire cache_diag_pkg::asi_req_t req,     // Alternate-space request
  output var  cache_diag_pkg::asi_rsp_t rsp      // Registered answer
);
  localparam int IDXW = $clog2(LINES);
  localparam int WDXW = $clog2(WORDS);
  localparam int TAGW = `CD_TAG_HI - `CD_TAG_LO + 2;
  localparam int NCB  = 4;

  function automatic logic large_cap(input cache_diag_pkg::cap_t c);
    large_cap = (c == cache_diag_pkg::CAP_16K) || (c == cache_diag_pkg::CAP_8K) ||
                (c == cache_diag_pkg::CAP_4K);
  endfunction

  function automatic logic [30:0] bank_limit(input cache_diag_pkg::cap_t c);
    case (c)
      cache_diag_pkg::CAP_16K: bank_limit = `CD_LIM_16K;
      cache_diag_pkg::CAP_8K:  bank_limit = `CD_LIM_8K;
      cache_diag_pkg::CAP_4K:  bank_limit = `CD_LIM_4K;
      default:                 bank_limit = `CD_LIM_SMALL;
    endcase
  endfunction

  // Valid flags kept apart from the tag so bulk clear never touches tag bits
  function automatic logic [7:0] pack_valid(input logic [31:0] w);
    pack_valid = {w[`CD_B10], w[`CD_SBV_HI:`CD_SBV_LO], w[`CD_SBV2_HI:`CD_SBV2_LO]};
  endfunction

  function automatic logic [31:0] compose_tag(input cache_diag_pkg::cap_t c,
                                              input logic bank2,
                                              input logic [TAGW-1:0] t,
                                              input logic [7:0] v,
                                              input logic lru,
                                              input logic lk);
    logic [31:0] r;
    r = '0;
    r[`CD_TAG_HI:`CD_TAG_LO] = t[TAGW-1:1];
    if (c == cache_diag_pkg::CAP_16K) begin
      r[`CD_B12] = 1'b0;
    end
    if (c == cache_diag_pkg::CAP_16K || c == cache_diag_pkg::CAP_8K) begin
      r[`CD_B11] = 1'b0;
    end
    if (large_cap(c)) begin
      r[`CD_B10] = v[7];
      r[`CD_SBV2_HI:`CD_SBV2_LO] = v[2:0];
    end
    r[`CD_SBV_HI:`CD_SBV_LO] = v[6:3];
    r[`CD_PRIV] = t[0];
    r[`CD_LRU] = (!bank2 && c != cache_diag_pkg::CAP_1K) ? lru : 1'b0;
    r[`CD_LOCK] = lk;
    compose_tag = r;
  endfunction

  // Storage: index {cache, bank}, cache 0 instruction, 1 data
  logic [TAGW-1:0] tag_mem   [NCB][LINES];
  logic [31:0]     data_mem  [NCB][WORDS];
  logic [7:0]      vld_reg   [NCB][LINES];
  logic            lock_reg  [NCB][LINES];
  logic            lru_reg   [2][LINES];
  cache_diag_pkg::asi_rsp_t rsp_reg;
  cache_diag_pkg::asi_rsp_t rsp_next;

  // Request decode
  logic            is_itag;
  logic            is_dtag;
  logic            is_idata;
  logic            is_ddata;
  logic            is_tag;
  logic            is_data;
  logic            hit;
  logic            dcache;
  logic            bank2;
  logic [1:0]      cb;
  logic [30:0]     ofs;
  logic [30:0]     inv_ofs;
  logic            bank_ok;
  logic            in_rng;
  logic            inv_hit;
  logic [IDXW-1:0] idx;
  logic [WDXW-1:0] widx;
  logic            tag_wr;
  logic            inv_wr;
  logic            data_wr;
  logic [31:0]     wd;

  assign is_itag  = req.asi == `CD_ASI_ITAG;
  assign is_dtag  = req.asi == `CD_ASI_DTAG;
  assign is_idata = req.asi == `CD_ASI_IDATA;
  assign is_ddata = req.asi == `CD_ASI_DDATA;
  assign is_tag   = is_itag || is_dtag;
  assign is_data  = is_idata || is_ddata;
  assign hit      = (is_tag || is_data) && (req.rd || req.wr);
  assign dcache   = is_dtag || is_ddata;
  assign bank2    = req.addr[`CD_BANK_BIT];
  assign cb       = {dcache, bank2};
  assign ofs      = req.addr[30:0];
  assign wd       = req.wdata;
  assign inv_ofs  = (cap_sel == cache_diag_pkg::CAP_16K) ? `CD_INV_OFS_16K
                                                         : `CD_INV_OFS_OTHER;
  // Direct-mapped 1KB lives only in bank two
  assign bank_ok  = bank2 || (cap_sel != cache_diag_pkg::CAP_1K);
  assign in_rng   = bank_ok && (ofs < bank_limit(cap_sel));
  assign inv_hit  = is_tag && bank_ok && (ofs == inv_ofs);

  always_comb begin
    if (large_cap(cap_sel)) begin
      idx = IDXW'(ofs[`CD_LINE32_HI:`CD_LINE32_LO]);
    end else begin
      idx = IDXW'(ofs[`CD_LINE16_HI:`CD_LINE16_LO]);
    end
  end

  assign widx    = WDXW'(ofs[`CD_WORD_HI:`CD_WORD_LO]);
  assign tag_wr  = req.wr && is_tag && in_rng && !inv_hit;
  assign inv_wr  = req.wr && inv_hit;
  assign data_wr = req.wr && is_data && in_rng;

  // Tag and privilege bits carry no reset
  always_ff @(posedge clk_sys) begin
    if (tag_wr) begin
      tag_mem[cb][idx] <= {wd[`CD_TAG_HI:`CD_TAG_LO], wd[`CD_PRIV]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (data_wr) begin
      data_mem[cb][widx] <= wd;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < NCB; k++) begin
        for (int i = 0; i < LINES; i++) begin
          vld_reg[k][i] <= '0;
        end
      end
    end else if (tag_wr) begin
      vld_reg[cb][idx] <= pack_valid(wd);
    end else if (inv_wr && wd[`CD_INV_VALID]) begin
      for (int i = 0; i < LINES; i++) begin
        vld_reg[cb][i] <= '0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < NCB; k++) begin
        for (int i = 0; i < LINES; i++) begin
          lock_reg[k][i] <= 1'b0;
        end
      end
    end else if (tag_wr) begin
      lock_reg[cb][idx] <= wd[`CD_LOCK];
    end else if (inv_wr && wd[`CD_INV_LRU_LOCK]) begin
      for (int i = 0; i < LINES; i++) begin
        lock_reg[cb][i] <= 1'b0;
      end
    end
  end

  // Only bank one owns an LRU bit, so the array is per cache
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < 2; k++) begin
        for (int i = 0; i < LINES; i++) begin
          lru_reg[k][i] <= 1'b0;
        end
      end
    end else if (tag_wr && !bank2) begin
      lru_reg[dcache][idx] <= wd[`CD_LRU];
    end else if (inv_wr && !bank2 && wd[`CD_INV_LRU_LOCK]) begin
      for (int i = 0; i < LINES; i++) begin
        lru_reg[dcache][i] <= 1'b0;
      end
    end
  end

  // Invalidate register is write only and reads back as zero
  always_comb begin
    rsp_next          = '0;
    rsp_next.ack      = hit;
    rsp_next.unmapped = hit && !in_rng && !inv_hit;
    if (req.rd && is_tag && in_rng && !inv_hit) begin
      rsp_next.rdata = compose_tag(cap_sel, bank2, tag_mem[cb][idx], vld_reg[cb][idx],
                                   lru_reg[dcache][idx], lock_reg[cb][idx]);
    end else if (req.rd && is_data && in_rng) begin
      rsp_next.rdata = data_mem[cb][widx];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  assign rsp = rsp_reg;

  // Helpers read only by the checks below
  function automatic logic bank_any_valid(input logic [1:0] k);
    logic a;
    a = 1'b0;
    for (int i = 0; i < LINES; i++) begin
      a = a | (|vld_reg[k][i]);
    end
    bank_any_valid = a;
  endfunction

  function automatic logic bank_any_lock(input logic [1:0] k);
    logic a;
    a = 1'b0;
    for (int i = 0; i < LINES; i++) begin
      a = a | lock_reg[k][i];
    end
    bank_any_lock = a;
  endfunction

  function automatic logic bank_any_lru(input logic k);
    logic a;
    a = 1'b0;
    for (int i = 0; i < LINES; i++) begin
      a = a | lru_reg[k][i];
    end
    bank_any_lru = a;
  endfunction

  logic [1:0]      chk_cb_reg;
  logic [IDXW-1:0] chk_idx_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chk_cb_reg  <= '0;
      chk_idx_reg <= '0;
    end else begin
      chk_cb_reg  <= cb;
      chk_idx_reg <= idx;
    end
  end

  AST_ACK_NEXT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hit |=> rsp.ack ##1 !rsp.ack || $past(hit))
    else $error("Request not answered in the next cycle");

  AST_NO_STRAY_ACK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !hit |=> !rsp.ack)
    else $error("Answer without a request");

  AST_SMALL_BANK1_UNMAPPED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (hit && cap_sel == cache_diag_pkg::CAP_1K && !bank2) |=> (rsp.unmapped && rsp.rdata == '0))
    else $error("Bank one decoded at the smallest capacity");

  AST_INV_VALID_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (inv_wr && wd[`CD_INV_VALID]) |=> !bank_any_valid(chk_cb_reg))
    else $error("Valid bits survived a bulk invalidate");

  AST_INV_LOCK_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (inv_wr && wd[`CD_INV_LRU_LOCK]) |=> !bank_any_lock(chk_cb_reg))
    else $error("Lock bits survived a bulk invalidate");

  AST_LOCK_STORED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tag_wr |=> lock_reg[chk_cb_reg][chk_idx_reg] == $past(wd[`CD_LOCK]))
    else $error("Lock flag not stored by a tag write");

  AST_BANK2_LRU_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (req.rd && is_tag && bank2) |=> !rsp.rdata[`CD_LRU])
    else $error("Bank two tag shows an LRU bit");

  AST_16K_RESERVED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (req.rd && is_tag && cap_sel == cache_diag_pkg::CAP_16K)
      |=> rsp.rdata[`CD_B12:`CD_B11] == 2'h0)
    else $error("Reserved tag bits read non-zero at the largest capacity");

  AST_SMALL_SBV2_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (req.rd && is_tag && !large_cap(cap_sel)) |=> rsp.rdata[`CD_SBV2_HI:`CD_SBV2_LO] == 3'h0)
    else $error("Reserved valid bits read non-zero at small capacity");

  AST_INV_LRU_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (inv_wr && !bank2 && wd[`CD_INV_LRU_LOCK]) |=> !bank_any_lru(chk_cb_reg[1]))
    else $error("LRU bits survived a bulk invalidate");

  AST_UNMAPPED_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (hit && !in_rng && !inv_hit) |=> (rsp.unmapped && rsp.rdata == '0))
    else $error("Out of range access not flagged");

  AST_INV_READ_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (req.rd && inv_hit) |=> (!rsp.unmapped && rsp.rdata == '0))
    else $error("Invalidate register read back non-zero");

  AST_8K_RESERVED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (req.rd && is_tag && cap_sel == cache_diag_pkg::CAP_8K) |=> !rsp.rdata[`CD_B11])
    else $error("Reserved tag bit read non-zero at 8KB");

  AST_1K_NO_LRU: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (req.rd && is_tag && cap_sel == cache_diag_pkg::CAP_1K) |=> !rsp.rdata[`CD_LRU])
    else $error("LRU bit shown at the smallest capacity");

  AST_VALID_STORED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tag_wr |=> vld_reg[chk_cb_reg][chk_idx_reg] ==
      $past({wd[`CD_B10], wd[`CD_SBV_HI:`CD_SBV_LO], wd[`CD_SBV2_HI:`CD_SBV2_LO]}))
    else $error("Valid flags not stored by a tag write");

  AST_LOCK_READBACK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (req.rd && is_tag && in_rng && !inv_hit) |=>
      rsp.rdata[`CD_LOCK] == $past(lock_reg[cb][idx]))
    else $error("Lock flag read back wrong");

  AST_LRU_READBACK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (req.rd && is_tag && in_rng && !inv_hit && !bank2 && cap_sel != cache_diag_pkg::CAP_1K)
      |=> rsp.rdata[`CD_LRU] == $past(lru_reg[dcache][idx]))
    else $error("LRU bit read back wrong");

  AST_WRITE_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (req.wr && hit) |=> rsp.rdata == '0)
    else $error("Write answered with data");
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Purpose: Self-checking bench for the cache diagnostic access block
// Assumes: One request at a time; capacity changed only while idle
// Notes:   Answers are sampled in the single cycle that they stand
`default_nettype none
`include "cache_diag_consts.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                     clk_sys;
  logic                     rst_n;
  cache_diag_pkg::cap_t     cap_sel;
  cache_diag_pkg::asi_req_t req;
  cache_diag_pkg::asi_rsp_t rsp;
  int                       fail_count;
  int                       total_checks;
  int                       cycles;

  cache_diagnostic_access #(
    .LINES (256),
    .WORDS (2048)
  ) cache_diagnostic_access_i (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .cap_sel (cap_sel),
    .req     (req),
    .rsp     (rsp)
  );

  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Generous ceiling; the sequence needs about ninety cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      $display("MISMATCH t=%0t run did not finish", $time);
      print_verdict();
    end
  end

  // Request held for exactly one taking edge, answer read one cycle later
  task automatic acc(input logic w, input logic [7:0] asi, input logic [31:0] a,
                     input logic [31:0] d, output cache_diag_pkg::asi_rsp_t r);
    @(posedge clk_sys);
    #1;
    req.rd = ~w;
    req.wr = w;
    req.asi = asi;
    req.addr = a;
    req.wdata = d;
    @(posedge clk_sys);
    #1;
    req.rd = 1'b0;
    req.wr = 1'b0;
    r = rsp;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input logic [31:0] m,
                     input string what);
    total_checks++;
    if ((got & {2'h3, m}) !== (exp & {2'h3, m})) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wrt(input logic [7:0] asi, input logic [31:0] a, input logic [31:0] d);
    cache_diag_pkg::asi_rsp_t r;
    acc(1'b1, asi, a, d, r);
    chk(r, {2'h2, 32'h0000_0000}, 32'hffff_ffff, "write answer");
  endtask

  task automatic rdm(input logic [7:0] asi, input logic [31:0] a, input logic [31:0] e,
                     input logic [31:0] m);
    cache_diag_pkg::asi_rsp_t r;
    acc(1'b0, asi, a, 32'h0000_0000, r);
    chk(r, {2'h2, e}, m, "read answer");
  endtask

  task automatic unm(input logic w, input logic [7:0] asi, input logic [31:0] a);
    cache_diag_pkg::asi_rsp_t r;
    acc(w, asi, a, 32'hffff_ffff, r);
    chk(r, {2'h3, 32'h0000_0000}, 32'hffff_ffff, "out of range");
  endtask

  initial begin
    cache_diag_pkg::asi_rsp_t r;
    rst_n = 1'b0;
    cap_sel = cache_diag_pkg::CAP_8K;
    req = '0;
    fail_count = 0;
    total_checks = 0;
    cycles = 0;
    repeat (8) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    // Only the state bits have a defined reset value
    rdm(`CD_ASI_ITAG, 32'h0000_0000, 32'h0000_0000, 32'h0000_07df);
    rdm(`CD_ASI_DTAG, 32'h8000_0000, 32'h0000_0000, 32'h0000_07df);

    cap_sel = cache_diag_pkg::CAP_16K;
    wrt(`CD_ASI_ITAG, 32'h0000_1fe0, 32'hffff_ffff);
    rdm(`CD_ASI_ITAG, 32'h0000_1fe0, 32'hffff_e7ff, 32'hffff_ffff);
    wrt(`CD_ASI_ITAG, 32'h8000_0020, 32'hffff_ffdf);
    rdm(`CD_ASI_ITAG, 32'h8000_0020, 32'hffff_e7dd, 32'hffff_ffff);
    wrt(`CD_ASI_ITAG, 32'h8000_8000, 32'h0000_0003);
    rdm(`CD_ASI_ITAG, 32'h8000_0020, 32'hffff_e000, 32'hffff_ffff);
    rdm(`CD_ASI_ITAG, 32'h0000_1fe0, 32'hffff_e7ff, 32'hffff_ffff);
    rdm(`CD_ASI_ITAG, 32'h0000_8000, 32'h0000_0000, 32'hffff_ffff);
    wrt(`CD_ASI_IDATA, 32'h8000_1ffc, 32'h1234_5678);
    wrt(`CD_ASI_IDATA, 32'h0000_1ffc, 32'hcafe_0001);
    rdm(`CD_ASI_IDATA, 32'h8000_1ffc, 32'h1234_5678, 32'hffff_ffff);
    rdm(`CD_ASI_IDATA, 32'h0000_1ffc, 32'hcafe_0001, 32'hffff_ffff);
    unm(1'b0, `CD_ASI_IDATA, 32'h0000_2000);

    cap_sel = cache_diag_pkg::CAP_8K;
    wrt(`CD_ASI_DTAG, 32'h0000_0fe0, 32'hffff_ffff);
    rdm(`CD_ASI_DTAG, 32'h0000_0fe0, 32'hffff_f7ff, 32'hffff_ffff);
    wrt(`CD_ASI_DTAG, 32'h0000_1000, 32'h0000_0000);
    rdm(`CD_ASI_DTAG, 32'h0000_0fe0, 32'hffff_f7ff, 32'hffff_ffff);
    wrt(`CD_ASI_DTAG, 32'h0000_1000, 32'h0000_0001);
    rdm(`CD_ASI_DTAG, 32'h0000_0fe0, 32'hffff_f023, 32'hffff_ffff);
    wrt(`CD_ASI_DTAG, 32'h0000_1000, 32'h0000_0002);
    rdm(`CD_ASI_DTAG, 32'h0000_0fe0, 32'hffff_f020, 32'hffff_ffff);
    unm(1'b0, `CD_ASI_DTAG, 32'h0000_1020);

    cap_sel = cache_diag_pkg::CAP_4K;
    wrt(`CD_ASI_DDATA, 32'h8000_07fc, 32'h0f0f_a5a5);
    rdm(`CD_ASI_DDATA, 32'h8000_07fc, 32'h0f0f_a5a5, 32'hffff_ffff);
    unm(1'b1, `CD_ASI_DDATA, 32'h8000_0800);

    cap_sel = cache_diag_pkg::CAP_2K;
    wrt(`CD_ASI_DTAG, 32'h0000_03f0, 32'hffff_ffff);
    wrt(`CD_ASI_DTAG, 32'h0000_03e0, 32'h0000_0000);
    rdm(`CD_ASI_DTAG, 32'h0000_03f0, 32'hffff_ffe3, 32'hffff_ffe3);
    wrt(`CD_ASI_DTAG, 32'h0000_1000, 32'h0000_0001);
    rdm(`CD_ASI_DTAG, 32'h0000_03f0, 32'hffff_fc23, 32'hffff_ffe3);

    cap_sel = cache_diag_pkg::CAP_1K;
    unm(1'b0, `CD_ASI_ITAG, 32'h0000_0000);
    wrt(`CD_ASI_ITAG, 32'h8000_03f0, 32'hffff_ffff);
    rdm(`CD_ASI_ITAG, 32'h8000_03f0, 32'hffff_ffe1, 32'hffff_ffe3);
    unm(1'b0, `CD_ASI_ITAG, 32'h8000_0400);

    // A space outside the four must get no answer at all
    acc(1'b0, 8'h01, 32'h0000_0000, 32'h0000_0000, r);
    chk(r, 34'h0_0000_0000, 32'hffff_ffff, "foreign space answered");

    // Second reset in mid-run must clear state bits again
    cap_sel = cache_diag_pkg::CAP_8K;
    wrt(`CD_ASI_ITAG, 32'h0000_0020, 32'hffff_ffff);
    rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    rdm(`CD_ASI_ITAG, 32'h0000_0020, 32'h0000_0000, 32'h0000_07df);
    print_verdict();
  end
endmodule
`default_nettype wire
